// File: rtl/cpuam_defs.svh
`ifndef CPUAM_DEFS_SVH
`define CPUAM_DEFS_SVH
// Function
// - Two 8-bit accumulators, paired as 16-bit
// - Index plus 5/9/16-bit constant or accumulator
// - Stack pointer usable as base everywhere
// - Program counter holds next instruction address
// - Flag register: five flags, two masks, stop-disable
// - Words stored high byte at lower address
// - No alignment restriction on any access
// - Direct mode: high address byte is zero
// - Full address mode: 16-bit address from stream
// - Relative target is PC plus signed offset
// - Inline operand 8/16 bits; register-only uses registers
// - Short postbyte: base plus signed 5-bit offset
// - Constant offset: 9-bit or 16-bit form
// - 16-bit offset then pointer fetched indirectly
// - Auto pre/post step of 1..8, no PC
// - Accumulator offset: A, B or double
// - Double accumulator offset then indirect pointer
// - Prefix 18 hex selects second opcode page
// - Postbyte then zero, one or two extra bytes
// - Three queued bytes before instruction starts

// Opcode page switch and queue threshold
`define CPUAM_PAGE2_PREFIX 8'h18
`define CPUAM_QUEUE_MIN 4'h3
// Direct page high byte
`define CPUAM_DIRECT_HIGH 8'h00
// Reset values
`define CPUAM_FLAGS_RST 8'hD0
`define CPUAM_PC_RST 16'h0000
// Base register codes in the postbyte
`define CPUAM_RR_X 2'h0
`define CPUAM_RR_Y 2'h1
`define CPUAM_RR_STACK 2'h2
`define CPUAM_RR_PC 2'h3
// Accumulator offset codes
`define CPUAM_AA_A 2'h0
`define CPUAM_AA_B 2'h1
`define CPUAM_AA_D 2'h2
`define CPUAM_AA_D_IND 2'h3
`endif

// File: rtl/cpuam_pkg.sv
package cpuam_pkg;
    // Addressing mode class supplied with each opcode
    typedef enum logic [2:0] {
        MODE_REGISTER_ONLY = 3'h0,
        MODE_INLINE8 = 3'h1,
        MODE_INLINE16 = 3'h2,
        MODE_DIRECT = 3'h3,
        MODE_FULL_ADDRESS = 3'h4,
        MODE_REL8 = 3'h5,
        MODE_REL16 = 3'h6,
        MODE_POINTER_OFFSET = 3'h7
    } cpuam_mode_t;

    // Datapath register write select
    typedef enum logic [2:0] {
        REG_A = 3'h0,
        REG_B = 3'h1,
        REG_D = 3'h2,
        REG_X = 3'h3,
        REG_Y = 3'h4,
        REG_STACK = 3'h5,
        REG_PC = 3'h6,
        REG_FLAGS = 3'h7
    } cpuam_reg_t;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        S_OPC = 6'h01,
        S_POST = 6'h02,
        S_BYTES = 6'h04,
        S_CALC = 6'h08,
        S_PTR_HI = 6'h10,
        S_PTR_LO = 6'h20
    } cpuam_state_t;
endpackage : cpuam_pkg

// File: rtl/cpuam_index_if.sv
interface cpuam_index_if;
    logic [7:0] postbyte;
    logic [15:0] extension;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] stack;
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] b;
    logic [1:0] need;
    logic [15:0] ea;
    logic indirect;
    logic wb_en;
    logic [1:0] wb_sel;
    logic [15:0] wb_val;

    modport calc (
        input postbyte, extension, x, y, stack, pc, a, b,
        output need, ea, indirect, wb_en, wb_sel, wb_val
    );
    modport user (
        output postbyte, extension, x, y, stack, pc, a, b,
        input need, ea, indirect, wb_en, wb_sel, wb_val
    );
endinterface : cpuam_index_if

// File: rtl/cpuam_index.sv
`include "cpuam_defs.svh"

module cpuam_index (
    cpuam_index_if.calc ix
);
    logic [1:0] rr;
    logic [15:0] base;
    logic [15:0] off;
    logic [15:0] delta;

    // Postbyte decode and effective address sum
    always_comb begin
        rr = ix.postbyte[7:6];
        off = 16'h0000;
        delta = 16'h0000;
        ix.need = 2'h0;
        ix.indirect = 1'b0;
        ix.wb_en = 1'b0;
        if (ix.postbyte[7:5] == 3'h7) begin
            rr = ix.postbyte[4:3];
        end
        // Base select; stack pointer allowed in every form
        unique case (rr)
            `CPUAM_RR_X: base = ix.x;
            `CPUAM_RR_Y: base = ix.y;
            `CPUAM_RR_STACK: base = ix.stack;
            `CPUAM_RR_PC: base = ix.pc;
        endcase
        if (!ix.postbyte[5]) begin
            // Short signed offset, -16..+15
            off = {{11{ix.postbyte[4]}}, ix.postbyte[4:0]};
        end else if (ix.postbyte[7:5] != 3'h7) begin
            // Step 1..8; rr of PC falls into the long forms instead
            if (ix.postbyte[3]) begin
                delta = {12'hFFF, ix.postbyte[3:0]};
            end else begin
                delta = {12'h000, ix.postbyte[3:0]} + 16'h0001;
            end
            ix.wb_en = 1'b1;
        end else if (!ix.postbyte[2]) begin
            if (ix.postbyte[1]) begin
                // Two extension bytes, high byte first
                ix.need = 2'h2;
                off = ix.extension;
                ix.indirect = ix.postbyte[0];
            end else begin
                ix.need = 2'h1;
                off = {{8{ix.postbyte[0]}}, ix.extension[7:0]};
            end
        end else begin
            // Accumulator offsets are unsigned
            unique case (ix.postbyte[1:0])
                `CPUAM_AA_A: off = {8'h00, ix.a};
                `CPUAM_AA_B: off = {8'h00, ix.b};
                `CPUAM_AA_D: off = {ix.a, ix.b};
                `CPUAM_AA_D_IND: begin
                    off = {ix.a, ix.b};
                    ix.indirect = 1'b1;
                end
            endcase
        end
        // Pre form uses stepped base, post form the old one
        ix.wb_sel = rr;
        ix.wb_val = base + delta;
        if (ix.wb_en) begin
            ix.ea = ix.postbyte[4] ? base : base + delta;
        end else begin
            ix.ea = base + off;
        end
    end
endmodule : cpuam_index

// File: rtl/cpuam_decoder.sv
`include "cpuam_defs.svh"

module cpuam_decoder #(
    parameter int QLVL_W = 4,
    parameter logic [15:0] RESET_PC = `CPUAM_PC_RST
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] q_byte_i,
    input wire logic q_valid_i,
    input wire cpuam_pkg::cpuam_mode_t q_mode_i,
    input wire logic [QLVL_W-1:0] q_level_i,
    output logic q_ready_o,
    output logic mem_req_o,
    output logic [15:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic wr_en_i,
    input wire cpuam_pkg::cpuam_reg_t wr_sel_i,
    input wire logic [15:0] wr_data_i,
    output logic done_o,
    output logic [7:0] opcode_o,
    output logic page2_o,
    output cpuam_pkg::cpuam_mode_t mode_o,
    output logic [15:0] ea_o,
    output logic [15:0] operand_o,
    output logic [7:0] acc_a_o,
    output logic [7:0] acc_b_o,
    output logic [15:0] index_x_o,
    output logic [15:0] index_y_o,
    output logic [15:0] stack_pointer_o,
    output logic [15:0] pc_o,
    output logic [7:0] flag_register_o
);
    import cpuam_pkg::*;

    cpuam_state_t st_q, st_d;
    cpuam_mode_t mode_q, mode_d;
    logic page_q, page_d;
    logic pg_out_q, pg_out_d;
    logic [7:0] opc_q, opc_d;
    logic [7:0] post_q, post_d;
    logic [15:0] ext_q, ext_d;
    logic [1:0] need_q, need_d;
    logic [15:0] ea_q, ea_d;
    logic [7:0] ptr_hi_q, ptr_hi_d;
    logic mreq_q, mreq_d;
    logic [15:0] maddr_q, maddr_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic [7:0] a_q, a_d;
    logic [7:0] b_q, b_d;
    logic [15:0] x_q, x_d;
    logic [15:0] y_q, y_d;
    logic [15:0] stk_q, stk_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0] flg_q, flg_d;
    logic take;

    cpuam_index_if ixb ();

    // Byte leaves the queue only on valid and registered ready
    assign take = q_valid_i && ready_q;

    // Postbyte is seen live while it is being taken
    assign ixb.postbyte = (st_q == S_POST) ? q_byte_i : post_q;
    assign ixb.extension = ext_q;
    assign ixb.x = x_q;
    assign ixb.y = y_q;
    assign ixb.stack = stk_q;
    assign ixb.pc = pc_q;
    assign ixb.a = a_q;
    assign ixb.b = b_q;

    cpuam_index u_index (
        .ix(ixb.calc)
    );

    // Instruction sequencer
    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        page_d = page_q;
        pg_out_d = pg_out_q;
        opc_d = opc_q;
        post_d = post_q;
        ext_d = ext_q;
        need_d = need_q;
        ea_d = ea_q;
        ptr_hi_d = ptr_hi_q;
        mreq_d = mreq_q;
        maddr_d = maddr_q;
        done_d = 1'b0;
        unique case (st_q)
            S_OPC: begin
                if (take) begin
                    if (q_byte_i == `CPUAM_PAGE2_PREFIX && !page_q) begin
                        page_d = 1'b1;
                    end else begin
                        opc_d = q_byte_i;
                        // Page kept with the opcode, valid beside done
                        pg_out_d = page_q;
                        mode_d = q_mode_i;
                        ext_d = 16'h0000;
                        unique case (q_mode_i)
                            MODE_REGISTER_ONLY: st_d = S_CALC;
                            MODE_POINTER_OFFSET: st_d = S_POST;
                            MODE_INLINE8, MODE_DIRECT, MODE_REL8: begin
                                need_d = 2'h1;
                                st_d = S_BYTES;
                            end
                            MODE_INLINE16, MODE_FULL_ADDRESS,
                            MODE_REL16: begin
                                need_d = 2'h2;
                                st_d = S_BYTES;
                            end
                        endcase
                    end
                end
            end
            S_POST: begin
                if (take) begin
                    post_d = q_byte_i;
                    need_d = ixb.need;
                    st_d = (ixb.need == 2'h0) ? S_CALC : S_BYTES;
                end
            end
            S_BYTES: begin
                // Shift in, so the first byte ends up high
                if (take) begin
                    ext_d = {ext_q[7:0], q_byte_i};
                    need_d = need_q - 2'h1;
                    if (need_q == 2'h1) begin
                        st_d = S_CALC;
                    end
                end
            end
            S_CALC: begin
                // PC has passed every byte of the instruction here
                done_d = 1'b1;
                page_d = 1'b0;
                st_d = S_OPC;
                unique case (mode_q)
                    MODE_DIRECT:
                        ea_d = {`CPUAM_DIRECT_HIGH, ext_q[7:0]};
                    MODE_FULL_ADDRESS: ea_d = ext_q;
                    MODE_REL8:
                        ea_d = pc_q + {{8{ext_q[7]}}, ext_q[7:0]};
                    MODE_REL16: ea_d = pc_q + ext_q;
                    MODE_POINTER_OFFSET: begin
                        ea_d = ixb.ea;
                        if (ixb.indirect) begin
                            // Pointer read replaces the done pulse
                            done_d = 1'b0;
                            page_d = page_q;
                            mreq_d = 1'b1;
                            maddr_d = ixb.ea;
                            st_d = S_PTR_HI;
                        end
                    end
                    default: ea_d = 16'h0000;
                endcase
            end
            S_PTR_HI: begin
                // No alignment check, any byte address is read
                if (mem_ack_i) begin
                    ptr_hi_d = mem_rdata_i;
                    maddr_d = maddr_q + 16'h0001;
                    st_d = S_PTR_LO;
                end
            end
            S_PTR_LO: begin
                if (mem_ack_i) begin
                    ea_d = {ptr_hi_q, mem_rdata_i};
                    mreq_d = 1'b0;
                    done_d = 1'b1;
                    page_d = 1'b0;
                    st_d = S_OPC;
                end
            end
        endcase
        // Opening byte waits for three queued bytes
        if (st_d == S_OPC) begin
            ready_d = (q_level_i >= `CPUAM_QUEUE_MIN);
        end else begin
            ready_d = (st_d == S_POST) || (st_d == S_BYTES);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= S_OPC;
            mode_q <= MODE_REGISTER_ONLY;
            page_q <= 1'b0;
            pg_out_q <= 1'b0;
            opc_q <= 8'h00;
            post_q <= 8'h00;
            ext_q <= 16'h0000;
            need_q <= 2'h0;
            ea_q <= 16'h0000;
            ptr_hi_q <= 8'h00;
            mreq_q <= 1'b0;
            maddr_q <= 16'h0000;
            ready_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            page_q <= page_d;
            pg_out_q <= pg_out_d;
            opc_q <= opc_d;
            post_q <= post_d;
            ext_q <= ext_d;
            need_q <= need_d;
            ea_q <= ea_d;
            ptr_hi_q <= ptr_hi_d;
            mreq_q <= mreq_d;
            maddr_q <= maddr_d;
            ready_q <= ready_d;
            done_q <= done_d;
        end
    end

    // Programmer-visible registers
    always_comb begin
        a_d = a_q;
        b_d = b_q;
        x_d = x_q;
        y_d = y_q;
        stk_d = stk_q;
        flg_d = flg_q;
        // Every consumed byte advances the next-instruction address, unless REG_PC is written in the same cycle
        pc_d = take ? pc_q + 16'h0001 : pc_q;
        if (wr_en_i) begin
            unique case (wr_sel_i)
                REG_A: a_d = wr_data_i[7:0];
                REG_B: b_d = wr_data_i[7:0];
                REG_D: begin
                    a_d = wr_data_i[15:8];
                    b_d = wr_data_i[7:0];
                end
                REG_X: x_d = wr_data_i;
                REG_Y: y_d = wr_data_i;
                REG_STACK: stk_d = wr_data_i;
                REG_PC: pc_d = wr_data_i;
                REG_FLAGS: flg_d = wr_data_i[7:0];
            endcase
        end
        // Auto step wins over a datapath write to the same base
        if (st_q == S_CALC && mode_q == MODE_POINTER_OFFSET && ixb.wb_en) begin
            unique case (ixb.wb_sel)
                `CPUAM_RR_X: x_d = ixb.wb_val;
                `CPUAM_RR_Y: y_d = ixb.wb_val;
                `CPUAM_RR_STACK: stk_d = ixb.wb_val;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_q <= 8'h00;
            b_q <= 8'h00;
            x_q <= 16'h0000;
            y_q <= 16'h0000;
            stk_q <= 16'h0000;
            pc_q <= RESET_PC;
            flg_q <= `CPUAM_FLAGS_RST;
        end else begin
            a_q <= a_d;
            b_q <= b_d;
            x_q <= x_d;
            y_q <= y_d;
            stk_q <= stk_d;
            pc_q <= pc_d;
            flg_q <= flg_d;
        end
    end

    // Outputs straight from flops
    assign q_ready_o = ready_q;
    assign mem_req_o = mreq_q;
    assign mem_addr_o = maddr_q;
    assign done_o = done_q;
    assign opcode_o = opc_q;
    assign page2_o = pg_out_q;
    assign mode_o = mode_q;
    assign ea_o = ea_q;
    assign operand_o = ext_q;
    assign acc_a_o = a_q;
    assign acc_b_o = b_q;
    assign index_x_o = x_q;
    assign index_y_o = y_q;
    assign stack_pointer_o = stk_q;
    assign pc_o = pc_q;
    assign flag_register_o = flg_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_direct_page: assert property (
        done_q && mode_q == MODE_DIRECT |-> ea_q[15:8] == 8'h00
    ) else $error("direct address high byte not zero");

    a_full_addr: assert property (
        done_q && mode_q == MODE_FULL_ADDRESS |-> ea_q == ext_q
    ) else $error("full address differs from stream bytes");

    a_rel_target: assert property (
        done_q && mode_q == MODE_REL8
        |-> ea_q == pc_q + {{8{ext_q[7]}}, ext_q[7:0]}
    ) else $error("relative target wrong");

    a_inline_narrow: assert property (
        done_q && mode_q == MODE_INLINE8 |-> ext_q[15:8] == 8'h00
    ) else $error("narrow inline operand has high byte");

    a_prefix_page: assert property (
        st_q == S_OPC && take && !page_q
        && q_byte_i == `CPUAM_PAGE2_PREFIX
        |=> page_q && st_q == S_OPC
    ) else $error("prefix did not select second page");

    a_queue_level: assert property (
        st_q == S_OPC && !ready_q ##1 st_q == S_OPC && ready_q
        |-> $past(q_level_i) >= `CPUAM_QUEUE_MIN
    ) else $error("opcode accepted with short queue");

    a_pointer_order: assert property (
        st_q == S_PTR_HI && mem_ack_i
        |=> mreq_q && maddr_q == $past(maddr_q) + 16'h0001
    ) else $error("pointer low byte not at next address");

    a_pointer_word: assert property (
        st_q == S_PTR_LO && mem_ack_i
        |=> done_q && ea_q == {$past(ptr_hi_q), $past(mem_rdata_i)}
    ) else $error("indirect pointer assembled wrong");

    a_double_acc: assert property (
        wr_en_i && wr_sel_i == REG_D && st_q != S_CALC
        |=> {a_q, b_q} == $past(wr_data_i)
    ) else $error("double accumulator write lost");

    a_pc_advance: assert property (
        take && !wr_en_i |=> pc_q == $past(pc_q) + 16'h0001
    ) else $error("program counter did not follow bytes");

    a_no_pc_step: assert property (
        st_q == S_CALC && mode_q == MODE_POINTER_OFFSET && ixb.wb_en
        |-> ixb.wb_sel != `CPUAM_RR_PC
    ) else $error("auto step chose program counter");

    a_request_hold: assert property (
        mreq_q && !mem_ack_i |=> mreq_q && $stable(maddr_q)
    ) else $error("memory request dropped before ack");
endmodule : cpuam_decoder

// File: test/cpuam_mem_model.sv
// Operand memory behind the pointer fetch port, random latency
module cpuam_mem_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic [15:0] mem_addr_i,
    output logic mem_ack_o,
    output logic [7:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 32'h796FFF08;
    int wait_q;

    // One ack per byte, then a gap so the next address is seen settled
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 8'h00;
            wait_q <= 0;
        end else if (mem_req_i && !mem_ack_o && wait_q == 0) begin
            mem_ack_o <= 1'b1;
            // Any byte address answers, word order is up to the reader
            mem_rdata_o <= mem_addr_i[15:8] ^ ~mem_addr_i[7:0];
            wait_q <= $unsigned($random(seed)) % 3;
        end else begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o; // Data line is junk outside an ack
            if (mem_req_i && !mem_ack_o) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : cpuam_mem_model

// File: test/testbench.sv
`include "cpuam_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import cpuam_pkg::*;
    logic sys_clk_i, rst_i, q_valid_i, q_ready_o, mem_req_o, mem_ack_i;
    logic wr_en_i, done_o, page2_o;
    logic [7:0] q_byte_i, mem_rdata_i, opcode_o, acc_a_o, acc_b_o;
    logic [7:0] flag_register_o, ma, mb, mf;
    logic [3:0] q_level_i;
    logic [15:0] mem_addr_o, wr_data_i, ea_o, operand_o, index_x_o;
    logic [15:0] index_y_o, stack_pointer_o, pc_o, mx, my, ms, mpc;
    cpuam_mode_t q_mode_i, mode_o;
    cpuam_reg_t wr_sel_i;
    int seed, error_cnt, num_checks;
    logic [31:0] r;

    cpuam_decoder dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .q_byte_i(q_byte_i),
        .q_valid_i(q_valid_i), .q_mode_i(q_mode_i), .q_level_i(q_level_i),
        .q_ready_o(q_ready_o), .mem_req_o(mem_req_o),
        .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i),
        .wr_data_i(wr_data_i), .done_o(done_o), .opcode_o(opcode_o),
        .page2_o(page2_o), .mode_o(mode_o), .ea_o(ea_o),
        .operand_o(operand_o), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
        .index_x_o(index_x_o), .index_y_o(index_y_o),
        .stack_pointer_o(stack_pointer_o), .pc_o(pc_o),
        .flag_register_o(flag_register_o)
    );
    cpuam_mem_model mem (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i)
    );

    // 10 MHz core clock
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // Same byte pattern the memory model serves
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[15:8] ^ ~a[7:0];
    endfunction : pat

    task automatic cmp_regs;
        check(acc_a_o, ma);
        check(acc_b_o, mb);
        check(index_x_o, mx);
        check(index_y_o, my);
        check(stack_pointer_o, ms);
        check(pc_o, mpc);
        check(flag_register_o, mf);
    endtask : cmp_regs

    task automatic wr(input cpuam_reg_t s, input logic [15:0] d);
        wr_en_i <= 1'b1;
        wr_sel_i <= s;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
        case (s)
            REG_A: ma = d[7:0];
            REG_B: mb = d[7:0];
            REG_D: {ma, mb} = d;
            REG_X: mx = d;
            REG_Y: my = d;
            REG_STACK: ms = d;
            REG_PC: mpc = d;
            default: mf = d[7:0];
        endcase
        @(posedge sys_clk_i);
    endtask : wr

    // Offer one byte and hold it until an edge with ready high takes it
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        q_byte_i <= b;
        q_valid_i <= 1'b1;
        forever begin
            @(negedge sys_clk_i);
            if (q_ready_o === 1'b1) break;
            @(posedge sys_clk_i);
            n++;
            if (n > 50) begin
                error_cnt++;
                stop_test();
            end
        end
        @(posedge sys_clk_i);
    endtask : put

    task automatic run_instr(input cpuam_mode_t m, input bit pre,
                             input logic [7:0] op);
        logic [7:0] pb;
        logic [15:0] w, base, eff, step;
        logic [1:0] rr;
        int ne;
        bit two;
        pb = $random(seed);
        w = $random(seed);
        if (!pre && op == `CPUAM_PAGE2_PREFIX) op = 8'h00;
        two = m == MODE_INLINE16 || m == MODE_FULL_ADDRESS || m == MODE_REL16;
        ne = two ? 2 : (m == MODE_REGISTER_ONLY ? 0 : 1);
        rr = pb[7:5] == 3'b111 ? pb[4:3] : pb[7:6];
        if (m == MODE_POINTER_OFFSET) begin
            ne = (pb[7:5] == 3'b111 && !pb[2]) ? (pb[1] ? 2 : 1) : 0;
        end
        mpc = mpc + 16'(int'(pre) + 1 + ne + int'(m == MODE_POINTER_OFFSET));
        base = rr == 2'h0 ? mx : rr == 2'h1 ? my : rr == 2'h2 ? ms : mpc;
        case (m)
            MODE_DIRECT: eff = {`CPUAM_DIRECT_HIGH, w[7:0]};
            MODE_FULL_ADDRESS: eff = w;
            MODE_REL8: eff = mpc + {{8{w[7]}}, w[7:0]};
            MODE_REL16: eff = mpc + w;
            default: eff = 16'h0000;
        endcase
        if (m == MODE_POINTER_OFFSET) begin
            if (!pb[5]) begin
                eff = base + {{11{pb[4]}}, pb[4:0]};
            end else if (pb[7:5] != 3'b111) begin
                step = pb[3] ? {12'hFFF, pb[3:0]} : {12'h000, pb[3:0]} + 16'h1;
                eff = pb[4] ? base : base + step;
                if (rr == 2'h0) mx = base + step;
                else if (rr == 2'h1) my = base + step;
                else ms = base + step;
            end else if (!pb[2]) begin
                eff = base + (pb[1] ? w : {{8{pb[0]}}, w[7:0]});
            end else begin
                eff = base + (pb[1] ? {ma, mb} : {8'h00, pb[0] ? mb : ma});
            end
            if (pb[7:5] == 3'b111 && pb[1:0] == 2'b11) begin
                step = eff + 16'h1; // Address of the pointer's low byte
                eff = {pat(eff), pat(step)};
            end
        end
        if (pre) put(`CPUAM_PAGE2_PREFIX);
        q_mode_i <= m;
        put(op);
        if (m == MODE_POINTER_OFFSET) put(pb);
        if (ne == 2) put(w[15:8]);
        if (ne > 0) put(w[7:0]);
        q_valid_i <= 1'b0;
        q_byte_i <= ~q_byte_i;
        ne = 0;
        do begin
            @(negedge sys_clk_i);
            ne++;
        end while (done_o !== 1'b1 && ne < 40);
        check(done_o, 1'b1);
        check(opcode_o, op);
        check(page2_o, pre);
        check(mode_o, m);
        check(ea_o, eff);
        check(mem_req_o, 1'b0);
        if (m == MODE_POINTER_OFFSET && pb[7:5] == 3'b111
            && pb[1:0] == 2'b11) begin
            check(mem_addr_o, step);
        end
        if (m == MODE_INLINE8 || m == MODE_INLINE16) begin
            check(operand_o, two ? w : {8'h00, w[7:0]});
        end
        cmp_regs();
        @(posedge sys_clk_i);
    endtask : run_instr

    // Watchdog, far beyond the expected run length
    initial begin
        #(20000 * 100);
        error_cnt++;
        stop_test();
    end

    initial begin
        seed = 32'h796FFF08;
        rst_i = 1'b1;
        q_byte_i = 8'h00;
        q_valid_i = 1'b0;
        q_mode_i = MODE_REGISTER_ONLY;
        q_level_i = 4'h3;
        wr_en_i = 1'b0;
        wr_sel_i = REG_A;
        wr_data_i = 16'h0000;
        {ma, mb, mx, my, ms, mpc} = '0;
        mf = `CPUAM_FLAGS_RST;
        repeat (5) @(negedge sys_clk_i);
        cmp_regs();
        check(done_o, 1'b0);
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(cpuam_reg_t'(i), 16'($random(seed)));
            @(negedge sys_clk_i);
            cmp_regs();
            @(posedge sys_clk_i);
        end
        $display("test register writes done");
        // Queue below three bytes holds the decoder off
        q_level_i <= 4'h2;
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(q_ready_o, 1'b0);
        @(posedge sys_clk_i);
        q_level_i <= 4'h3;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(q_ready_o, 1'b1);
        @(posedge sys_clk_i);
        $display("test queue level done");
        for (int i = 0; i < 8; i++) begin
            run_instr(cpuam_mode_t'(i), 1'b0, 8'h3C);
        end
        run_instr(MODE_POINTER_OFFSET, 1'b1, `CPUAM_PAGE2_PREFIX);
        $display("test mode corners done");
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            q_level_i <= r[19:16] < 4'h3 ? 4'h3 : r[19:16];
            if (r[4]) wr(cpuam_reg_t'(r[7:5]), r[31:16]);
            run_instr(cpuam_mode_t'(r[2:0]), r[9], r[15:8]);
        end
        $display("test random decode done");
        stop_test();
    end
endmodule : testbench
